//--- core/dss_pkg.sv
package dss_pkg;

	// ***********************************
	// configuration: 8, 9, 18 or 36 bits
	// ***********************************
	localparam int DATA_W = 36;
	localparam int ADDR_W = (DATA_W <= 9) ? 22 : ((DATA_W == 18) ? 21 : 20);
	localparam int NIB_W = 4;
	localparam int LANE_W = 9;
	localparam int NIB_N = 2;
	localparam int LANE_N = 4;
	localparam int FIFO_DEPTH = 16;
	localparam int READY_ROOM = 4;

	// ***********************************
	// encodings and reset values
	// ***********************************
	localparam logic DIR_READ = 1'b1;
	localparam logic OE_N_RST = 1'b1;
	localparam logic READY_RST = 1'b1;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic half;
		logic [DATA_W-1:0] data;
		logic [DATA_W-1:0] en;
	} dss_wr_s;

	typedef enum logic [1:0] {RD_IDLE, RD_WORD0, RD_WORD1} dss_rd_e;

	// per-bit write enable from the active-low masks
	function automatic logic [DATA_W-1:0] dss_lane_en(input logic [NIB_N-1:0] nib_n,
		input logic [LANE_N-1:0] lane_n);
		logic [DATA_W-1:0] en;
		en = '0;
		for (int i = 0; i < DATA_W; i++) begin
			if (DATA_W == 8) begin
				en[i] = ~nib_n[i / NIB_W];
			end else begin
				en[i] = ~lane_n[i / LANE_W];
			end
		end
		return en;
	endfunction

endpackage

//--- core/dss_sram_port.sv
`timescale 1ns/100ps
// Notes on behaviour
// - x8: nibble masks sampled on the same edge as their data word
// - nibble mask 0 governs bits 3:0, mask 1 bits 7:4
// - deasserted nibble mask: input nibble dropped, stored nibble kept
// - byte masks sampled on the same edge as their data word
// - byte masks govern nine-bit lanes 8:0, 17:9, 26:18, 35:27
// - deasserted byte mask: lane ignored, stored byte kept
// - shared address sampled on the true input clock edge
// - two arrays per burst; address 22, 21 or 20 bits by width
// - address ignored when no access is selected
// - read words launched on both output clock edges, or input edges
// - read outputs released whenever the read port is idle
// - read data width matches the configured data width
// - direction at true edge with strobe low: high read, low write
// - true and complement output edges together launch the burst
// - accesses begin only on the true input clock edge
// - complement edge captures inputs and launches data in single clock mode
// - strobe low defines a cycle; each burst is two words
// - write data sampled on both true and complement edges

// ***********************************
// write word buffer
// ***********************************
module dss_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [W-1:0] in_data_in,
	// drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [W-1:0] out_data_out,
	// fill level
	output logic [$clog2(DEPTH):0] level_out
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [PW:0] count_r;
	logic push;
	logic pop;

	assign in_ready_out = (count_r != DEPTH[PW:0]);
	assign out_valid_out = (count_r != '0);
	assign out_data_out = mem[rd_ptr_r];
	assign level_out = count_r;
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;

	always_ff @(posedge clk_sys_in) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data_in;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end

	a_fifo_no_overflow: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(count_r <= DEPTH[PW:0]) && (count_r[PW-1:0] == wr_ptr_r - rd_ptr_r))
		else $error("fifo level and pointers disagree");

endmodule // dss_fifo

// ***********************************
// sram port logic
// ***********************************
module dss_sram_port (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// bus cycle
	input wire logic cycle_valid_n_in,
	input wire logic dir_read_in,
	input wire logic [dss_pkg::ADDR_W-1:0] addr_in,
	input wire logic k_edge_in,
	// write port
	input wire logic [dss_pkg::DATA_W-1:0] wr_data_in,
	input wire logic [dss_pkg::NIB_N-1:0] nibble_mask_n_in,
	input wire logic [dss_pkg::LANE_N-1:0] byte_mask_n_in,
	output logic wr_ready_out,
	// read port
	input wire logic single_clk_in,
	input wire logic c_edge_in,
	output logic [dss_pkg::DATA_W-1:0] rd_data_out,
	output logic rd_data_oe_n_out
);
	import dss_pkg::*;

	logic [DATA_W-1:0] mem0 [2**ADDR_W];
	logic [DATA_W-1:0] mem1 [2**ADDR_W];
	logic start;
	logic rd_start;
	logic wr_start;
	logic wr_act_r;
	logic [ADDR_W-1:0] wr_addr_r;
	logic push_v;
	logic push_rdy;
	dss_wr_s push_d;
	logic drn_v;
	logic drn_rdy;
	dss_wr_s drn_d;
	logic [$clog2(FIFO_DEPTH):0] fifo_level;
	logic [DATA_W-1:0] rd_buf0_r;
	logic [DATA_W-1:0] rd_buf1_r;
	logic [DATA_W-1:0] rd_word1_r;
	logic rd_pend_r;
	logic launch_true;
	logic consume;
	dss_rd_e rd_st_r;

	// ***********************************
	// bus cycle decode
	// ***********************************
	assign start = ~cycle_valid_n_in & k_edge_in;
	assign rd_start = start & (dir_read_in == DIR_READ);
	assign wr_start = start & (dir_read_in != DIR_READ);

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_act_r <= 1'b0;
		end else begin
			wr_act_r <= wr_start;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_addr_r <= '0;
		end else if (wr_start) begin
			wr_addr_r <= addr_in;
		end
	end

	// ***********************************
	// write capture into buffer
	// ***********************************
	assign push_v = wr_start | (wr_act_r & ~k_edge_in);

	always_comb begin
		push_d.addr = wr_start ? addr_in : wr_addr_r;
		push_d.half = ~wr_start;
		push_d.data = wr_data_in;
		push_d.en = dss_lane_en(nibble_mask_n_in, byte_mask_n_in);
	end

	dss_fifo #(
		.W($bits(dss_wr_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.in_valid_in(push_v),
		.in_ready_out(push_rdy),
		.in_data_in(push_d),
		.out_valid_out(drn_v),
		.out_ready_in(drn_rdy),
		.out_data_out(drn_d),
		.level_out(fifo_level)
	);

	// read lookup owns the arrays for its cycle
	assign drn_rdy = ~rd_start;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ready_out <= READY_RST;
		end else begin
			wr_ready_out <= (fifo_level <= ($clog2(FIFO_DEPTH) + 1)'(FIFO_DEPTH - READY_ROOM));
		end
	end

	// ***********************************
	// array write and read lookup
	// ***********************************
	always_ff @(posedge clk_sys_in) begin
		if (drn_v && drn_rdy) begin
			if (drn_d.half) begin
				mem1[drn_d.addr] <= (mem1[drn_d.addr] & ~drn_d.en) | (drn_d.data & drn_d.en);
			end else begin
				mem0[drn_d.addr] <= (mem0[drn_d.addr] & ~drn_d.en) | (drn_d.data & drn_d.en);
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rd_start) begin
			rd_buf0_r <= mem0[addr_in];
			rd_buf1_r <= mem1[addr_in];
		end
	end

	// ***********************************
	// read launch
	// ***********************************
	assign launch_true = single_clk_in ? k_edge_in : c_edge_in;
	assign consume = rd_pend_r & launch_true & (rd_st_r != RD_WORD0);

	// second word held at launch: a read taken on the launch edge refills the buffers
	always_ff @(posedge clk_sys_in) begin
		if (consume) begin
			rd_word1_r <= rd_buf1_r;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_pend_r <= 1'b0;
		end else if (rd_start) begin
			rd_pend_r <= 1'b1;
		end else if (consume) begin
			rd_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_st_r <= RD_IDLE;
			rd_data_out <= '0;
			rd_data_oe_n_out <= OE_N_RST;
		end else begin
			unique case (rd_st_r)
				RD_IDLE, RD_WORD1: begin
					if (consume) begin
						rd_st_r <= RD_WORD0;
						rd_data_out <= rd_buf0_r;
						rd_data_oe_n_out <= 1'b0;
					end else begin
						rd_st_r <= RD_IDLE;
						rd_data_oe_n_out <= 1'b1;
					end
				end
				RD_WORD0: begin
					rd_st_r <= RD_WORD1;
					rd_data_out <= rd_word1_r;
					rd_data_oe_n_out <= 1'b0;
				end
			endcase
		end
	end

	// ***********************************
	// checks
	// ***********************************
	logic chk_v_r;
	logic chk_half_r;
	logic [ADDR_W-1:0] chk_addr_r;
	logic [DATA_W-1:0] chk_old_r;
	logic [DATA_W-1:0] chk_data_r;
	logic [DATA_W-1:0] chk_en_r;
	logic [DATA_W-1:0] chk_now;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			chk_v_r <= 1'b0;
			chk_half_r <= 1'b0;
			chk_addr_r <= '0;
			chk_old_r <= '0;
			chk_data_r <= '0;
			chk_en_r <= '0;
		end else begin
			chk_v_r <= drn_v & drn_rdy;
			chk_half_r <= drn_d.half;
			chk_addr_r <= drn_d.addr;
			chk_old_r <= drn_d.half ? mem1[drn_d.addr] : mem0[drn_d.addr];
			chk_data_r <= drn_d.data;
			chk_en_r <= drn_d.en;
		end
	end

	assign chk_now = chk_half_r ? mem1[chk_addr_r] : mem0[chk_addr_r];

	a_masked_bits_kept: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		chk_v_r |-> ((chk_now & ~chk_en_r) == (chk_old_r & ~chk_en_r)))
		else $error("masked bits of stored word changed");

	a_enabled_bits_written: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		chk_v_r |-> ((chk_now & chk_en_r) == (chk_data_r & chk_en_r)))
		else $error("enabled bits not written");

	a_start_true_edge: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(push_v && !wr_act_r) |-> (k_edge_in && !cycle_valid_n_in))
		else $error("access started off the true edge");

	a_idle_no_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(cycle_valid_n_in && !wr_act_r) |-> !push_v)
		else $error("write word taken with strobe high");

	a_second_word: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(wr_start && push_rdy) ##1 !k_edge_in |-> push_v && push_d.half && (push_d.addr == $past(addr_in)))
		else $error("second write word not captured");

	a_addr_held: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		!wr_start |=> $stable(wr_addr_r))
		else $error("address taken without an access");

	a_read_no_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(rd_start && !wr_act_r) |-> !push_v)
		else $error("read cycle captured write data");

	a_launch_edge: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		$fell(rd_data_oe_n_out) |-> $past(launch_true) && (rd_data_out == $past(rd_buf0_r)))
		else $error("first read word off its launch edge");

	a_burst_two: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(rd_st_r == RD_WORD0) |=> !rd_data_oe_n_out && (rd_data_out == $past(rd_buf1_r, 2)))
		else $error("second read word missing");

	a_release_idle: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(!rd_pend_r && (rd_st_r != RD_WORD0)) |=> rd_data_oe_n_out)
		else $error("read outputs driven while idle");

	c_write_burst: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		wr_start ##1 (push_v && !k_edge_in));
	c_read_burst: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		rd_start ##[1:4] $fell(rd_data_oe_n_out) ##1 !rd_data_oe_n_out);
	c_single_clock_read: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		single_clk_in && $fell(rd_data_oe_n_out));
	c_masked_write: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		chk_v_r && (chk_en_r != '1) && (chk_en_r != '0));

endmodule // dss_sram_port

//--- dv/ddr_sio_sram_port_interface_tb.sv
`timescale 1ns/100ps
module ddr_sio_sram_port_interface_tb;
	import dss_pkg::*;
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic sc = 1'b1;
	logic c_lag = 1'b0;
	logic cyc_n, rd, k_e, c_e, wr_rdy, oe_n;
	logic [ADDR_W-1:0] a;
	logic [DATA_W-1:0] d, q;
	logic [LANE_N-1:0] m;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	always #4 clk_sys_in = ~clk_sys_in;
	dss_ctrl_model dss_ctrl_model_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .c_lag_in(c_lag), .cyc_n_out(cyc_n),
		.rd_out(rd), .addr_out(a), .k_edge_out(k_e), .c_edge_out(c_e), .data_out(d), .mask_n_out(m));
	dss_sram_port dss_sram_port_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cycle_valid_n_in(cyc_n),
		.dir_read_in(rd), .addr_in(a), .k_edge_in(k_e), .wr_data_in(d), .nibble_mask_n_in(m[NIB_N-1:0]),
		.byte_mask_n_in(m), .wr_ready_out(wr_rdy), .single_clk_in(sc), .c_edge_in(c_e),
		.rd_data_out(q), .rd_data_oe_n_out(oe_n));
	// ***********************************
	// checking and closing
	// ***********************************
	task automatic chk(input logic [DATA_W-1:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("checks=%0d mismatches=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			summarize();
		end
	end
	function automatic logic [DATA_W-1:0] mrg(input logic [DATA_W-1:0] o, n, input logic [LANE_N-1:0] mk);
		mrg = o;
		for (int i = 0; i < DATA_W; i++) begin
			if (!mk[i / LANE_W]) begin
				mrg[i] = n[i];
			end
		end
	endfunction
	// ***********************************
	// bus tasks
	// ***********************************
	task automatic wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d0, d1, input logic [LANE_N-1:0] m0, m1);
		dss_ctrl_model_i.burst(1'b0, ad, d0, d1, m0, m1, 1'b0, 1'b0);
	endtask
	task automatic rd_chk(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] e0, e1);
		logic early;
		early = !sc && c_lag;
		repeat (24) @(posedge clk_sys_in);
		dss_ctrl_model_i.burst(1'b1, ad, '1, '0, '0, '1, 1'b0, 1'b0);
		if (!early) begin
			#1;
			chk(oe_n, 1'b1);
			@(posedge clk_sys_in);
		end
		#1;
		chk(oe_n, 1'b0);
		chk(q, e0);
		@(posedge clk_sys_in);
		#1;
		chk(oe_n, 1'b0);
		chk(q, e1);
		@(posedge clk_sys_in);
		#1;
		chk(oe_n, 1'b1);
	endtask
	// ***********************************
	// scenarios
	// ***********************************
	task automatic t_reset;
		#1;
		chk(oe_n, OE_N_RST);
		chk(q, '0);
		chk(wr_rdy, READY_RST);
		$display("test reset done");
	endtask
	task automatic t_modes;
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_sys_in);
			sc <= i[0];
			c_lag <= ~i[0];
			wr(20'h0000a + i[19:0], 36'h123456789, 36'hfedcba987, 4'h0, 4'h0);
			rd_chk(20'h0000a + i[19:0], 36'h123456789, 36'hfedcba987);
		end
		$display("test modes done");
	endtask
	task automatic t_mask;
		wr(20'hfffff, 36'h0aaaaaaaa, 36'h055555555, 4'h0, 4'h0);
		wr(20'hfffff, 36'hf0f0f0f0f, 36'h30c30c30c, 4'ha, 4'h5);
		rd_chk(20'hfffff, mrg(36'h0aaaaaaaa, 36'hf0f0f0f0f, 4'ha), mrg(36'h055555555, 36'h30c30c30c, 4'h5));
		wr(20'hfffff, 36'h111111111, 36'h222222222, 4'hf, 4'hf);
		rd_chk(20'hfffff, mrg(36'h0aaaaaaaa, 36'hf0f0f0f0f, 4'ha), mrg(36'h055555555, 36'h30c30c30c, 4'h5));
		$display("test mask done");
	endtask
	task automatic t_idle;
		wr(20'h00055, 36'h0cafe0001, 36'h0cafe0002, 4'h0, 4'h0);
		dss_ctrl_model_i.burst(1'b0, 20'h00055, 36'h0dead0001, 36'h0dead0002, 4'h0, 4'h0, 1'b1, 1'b0);
		dss_ctrl_model_i.burst(1'b0, 20'h00055, 36'h0beef0001, 36'h0beef0002, 4'h0, 4'h0, 1'b0, 1'b1);
		rd_chk(20'h00055, 36'h0cafe0001, 36'h0cafe0002);
		$display("test idle done");
	endtask
	task automatic t_pair;
		wr(20'h00020, 36'h0a0a0a0a0, 36'h0a1a1a1a1, 4'h0, 4'h0);
		wr(20'h00021, 36'h0b0b0b0b0, 36'h0b1b1b1b1, 4'h0, 4'h0);
		repeat (24) @(posedge clk_sys_in);
		dss_ctrl_model_i.read_pair(20'h00020, 20'h00021);
		#1;
		chk(oe_n, 1'b0);
		chk(q, 36'h0a0a0a0a0);
		@(posedge clk_sys_in);
		#1;
		chk(q, 36'h0a1a1a1a1);
		@(posedge clk_sys_in);
		#1;
		chk(q, 36'h0b0b0b0b0);
		@(posedge clk_sys_in);
		#1;
		chk(q, 36'h0b1b1b1b1);
		@(posedge clk_sys_in);
		#1;
		chk(oe_n, 1'b1);
		$display("test pair done");
	endtask
	initial begin
		repeat (16) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		t_reset();
		t_modes();
		t_mask();
		t_idle();
		t_pair();
		summarize();
	end
endmodule // ddr_sio_sram_port_interface_tb

//--- dv/dss_ctrl_model.sv
`timescale 1ns/100ps
// ***********************************
// memory controller model
// ***********************************
module dss_ctrl_model (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// output clock phase: 1 puts the true output rise on complement input rises
	input wire logic c_lag_in,
	// bus to the port
	output logic cyc_n_out,
	output logic rd_out,
	output logic [dss_pkg::ADDR_W-1:0] addr_out,
	output logic k_edge_out,
	output logic c_edge_out,
	output logic [dss_pkg::DATA_W-1:0] data_out,
	output logic [dss_pkg::LANE_N-1:0] mask_n_out
);
	import dss_pkg::*;
	initial begin
		cyc_n_out = 1'b1;
		rd_out = 1'b0;
		addr_out = '0;
		data_out = '0;
		mask_n_out = '1;
	end
	// true and complement rises alternate
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			k_edge_out <= 1'b0;
		end else begin
			k_edge_out <= ~k_edge_out;
		end
	end
	assign c_edge_out = k_edge_out ^ c_lag_in;
	// off=1 presents the strobe on a complement rise
	task automatic burst(input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0, d1,
		input logic [LANE_N-1:0] m0, m1, input logic vld_n, input logic off);
		do @(posedge clk_sys_in); while (k_edge_out != off);
		cyc_n_out <= vld_n;
		rd_out <= rd;
		addr_out <= a;
		data_out <= d0;
		mask_n_out <= m0;
		@(posedge clk_sys_in);
		cyc_n_out <= 1'b1;
		rd_out <= ~rd;
		addr_out <= ~a;
		data_out <= d1;
		mask_n_out <= m1;
		@(posedge clk_sys_in);
		data_out <= ~d1;
		mask_n_out <= ~m1;
	endtask
	// two reads taken on consecutive true edges
	task automatic read_pair(input logic [ADDR_W-1:0] a0, a1);
		do @(posedge clk_sys_in); while (k_edge_out != 1'b0);
		cyc_n_out <= 1'b0;
		rd_out <= 1'b1;
		addr_out <= a0;
		@(posedge clk_sys_in);
		cyc_n_out <= 1'b1;
		addr_out <= ~a0;
		@(posedge clk_sys_in);
		cyc_n_out <= 1'b0;
		addr_out <= a1;
		@(posedge clk_sys_in);
		cyc_n_out <= 1'b1;
		rd_out <= 1'b0;
		addr_out <= ~a1;
	endtask
endmodule // dss_ctrl_model
